//--- inc/exec_params.svh
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
// Contract
// RL1: Increment-skip adds one to the file register; destination bit picks target; no flags.
// RL2: Increment-skip with zero result runs a no-operation instead of the next instruction.
// RL3: Absolute branch loads the 11-bit literal and latch bits 4:3 into the program counter.
// RL4: Absolute branch takes two cycles and leaves the flags untouched.
// RL5: OR-literal ORs the accumulator with an 8-bit literal into the accumulator; zero flag.
// RL6: Plain increment adds one to the file register; destination bit picks target; zero flag.
// RL7: OR-register ORs accumulator with file register; destination bit picks target; zero flag.
// RL8: Move copies file register to accumulator or back to itself; zero flag updates.
// RL9: Move back to the same file register still updates the zero flag.
// RL10: Zero flag set on zero result, cleared otherwise; plain instructions take one cycle.

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define EXEC_PC_RESET      13'h0000
`define EXEC_ACC_RESET     8'h00
`define EXEC_ZERO_RESET    1'b0

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define EXEC_LATCH_PC_HI   4
`define EXEC_LATCH_PC_LO   3
`define EXEC_DEST_ACC      1'b0
`define EXEC_DEST_FILE     1'b1

// ------------------------------------------------------------
// Timing counts, in instruction cycles
// ------------------------------------------------------------
`define EXEC_CYCLES_PLAIN  1
`define EXEC_CYCLES_LONG   2
`endif

//--- inc/exec_pkg.sv
package exec_pkg;
  typedef enum logic [2:0] {
    increment_skip_zero,
    increment_file,
    absolute_branch,
    or_literal_acc,
    or_acc_file,
    move_file,
    no_operation
  } exec_op_t;

  typedef enum logic {
    ST_RUN,
    ST_STALL
  } exec_state_t;
endpackage

//--- hdl/exec_alu.sv
`include "exec_params.svh"

module exec_alu
  import exec_pkg::*;
(
  input  wire exec_op_t   op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] file_data,
  input  wire logic [7:0] lit8,
  output logic      [7:0] result,
  output logic            result_zero
);
  // Increment wraps at 8 bits, so 0xff plus one gives zero
  always_comb begin
    case (op)
      increment_skip_zero,
      increment_file: result = 8'(file_data + 8'h01);   // [RL1] [RL6]
      or_literal_acc: result = acc | lit8;              // [RL5]
      or_acc_file:    result = acc | file_data;         // [RL7]
      move_file:      result = file_data;               // [RL8]
      default:        result = acc;
    endcase
  end

  assign result_zero = (result == 8'h00);               // [RL10]
endmodule

//--- hdl/increment_or_move_branch_exec.sv
`include "exec_params.svh"

module increment_or_move_branch_exec
  import exec_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        instr_valid,
  input  wire exec_op_t    instr_op,
  input  wire logic [6:0]  file_addr,
  input  wire logic        dest_bit,
  input  wire logic [10:0] literal,
  input  wire logic [7:0]  file_rdata,
  input  wire logic [4:0]  pc_high_latch,
  output logic             busy_q,
  output logic             done_q,
  output logic             nop_cycle_q,
  output logic [12:0]      pc_q,
  output logic [7:0]       acc_q,
  output logic             zero_q,
  output logic             file_we_q,
  output logic [6:0]       file_waddr_q,
  output logic [7:0]       file_wdata_q
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  exec_state_t state_q;
  exec_state_t state_d;
  logic [7:0]  result;
  logic        result_zero;

  wire take        = instr_valid && (state_q == ST_RUN);
  wire is_skip     = (instr_op == increment_skip_zero);
  wire is_branch   = (instr_op == absolute_branch);
  wire is_lit      = (instr_op == or_literal_acc);
  wire is_nop      = (instr_op == no_operation);
  wire to_file     = (dest_bit == `EXEC_DEST_FILE) && !is_lit && !is_branch && !is_nop;
  wire to_acc      = !to_file && !is_branch && !is_nop;
  wire sets_zero   = !is_skip && !is_branch && !is_nop;       // [RL1] [RL4]
  wire skip_taken  = is_skip && result_zero;                  // [RL2]
  wire long_instr  = is_branch || skip_taken;                 // [RL2] [RL4]
  wire [12:0] branch_target = {pc_high_latch[`EXEC_LATCH_PC_HI:`EXEC_LATCH_PC_LO],
                               literal};                      // [RL3]
  wire [12:0] pc_step = skip_taken ? 13'(pc_q + 13'h0002) : 13'(pc_q + 13'h0001);

  exec_alu u_alu (
    .op          (instr_op),
    .acc         (acc_q),
    .file_data   (file_rdata),
    .lit8        (literal[7:0]),
    .result      (result),
    .result_zero (result_zero)
  );

  // Any instruction arriving during the stall cycle is ignored: the issuer watches busy_q
  always_comb begin
    case (state_q)
      ST_RUN:   state_d = (take && long_instr) ? ST_STALL : ST_RUN;
      ST_STALL: state_d = ST_RUN;
      default:  state_d = ST_RUN;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ST_RUN;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      nop_cycle_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      busy_q      <= (state_d == ST_STALL);
      done_q      <= (take && !long_instr) || (state_q == ST_STALL);   // [RL10] [RL4]
      nop_cycle_q <= take && skip_taken;                               // [RL2]
    end
  end

  // ------------------------------------------------------------
  // Architectural state
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pc_q   <= `EXEC_PC_RESET;
      acc_q  <= `EXEC_ACC_RESET;
      zero_q <= `EXEC_ZERO_RESET;
    end else if (take) begin
      pc_q <= is_branch ? branch_target : pc_step;                 // [RL3] [RL2]
      if (to_acc) begin
        acc_q <= result;                                           // [RL1] [RL5] [RL6] [RL7] [RL8]
      end
      if (sets_zero) begin
        zero_q <= result_zero;                                     // [RL9] [RL10]
      end
    end
  end

  // Write port of the file register; a move to itself is still written so timing is uniform
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      file_we_q    <= 1'b0;
      file_waddr_q <= 7'h00;
      file_wdata_q <= 8'h00;
    end else begin
      file_we_q <= take && to_file;                                // [RL1] [RL6] [RL7] [RL8]
      if (take && to_file) begin
        file_waddr_q <= file_addr;
        file_wdata_q <= result;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_skip_dest;
    @(posedge clk_sys) disable iff (!rst_b)
    take && is_skip && !dest_bit |=> acc_q == 8'($past(file_rdata) + 8'h01)
      && zero_q == $past(zero_q);
  endproperty
  a_skip_dest: assert property (p_skip_dest) else $error("increment-skip result wrong"); // [RL1]

  property p_skip_nop;
    @(posedge clk_sys) disable iff (!rst_b)
    take && is_skip && file_rdata == 8'hff |=> busy_q && nop_cycle_q && !done_q ##1 done_q
      && !busy_q;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skip did not stall one cycle"); // [RL2]

  property p_branch_pc;
    @(posedge clk_sys) disable iff (!rst_b)
    take && is_branch |=> pc_q == {$past(pc_high_latch[4:3]), $past(literal)};
  endproperty
  a_branch_pc: assert property (p_branch_pc) else $error("branch target wrong"); // [RL3]

  property p_branch_two;
    @(posedge clk_sys) disable iff (!rst_b)
    take && is_branch |=> (busy_q && !done_q && $stable(zero_q) && !file_we_q) ##1 done_q;
  endproperty
  a_branch_two: assert property (p_branch_two) else $error("branch not two cycles"); // [RL4]

  property p_or_lit;
    @(posedge clk_sys) disable iff (!rst_b)
    take && is_lit |=> acc_q == ($past(acc_q) | $past(literal[7:0])) && !file_we_q
      && zero_q == (acc_q == 8'h00);
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("or-literal wrong"); // [RL5]

  property p_inc_file;
    @(posedge clk_sys) disable iff (!rst_b)
    take && instr_op == increment_file && dest_bit |=> file_we_q
      && file_wdata_q == 8'($past(file_rdata) + 8'h01) && zero_q == (file_wdata_q == 8'h00);
  endproperty
  a_inc_file: assert property (p_inc_file) else $error("increment to file wrong"); // [RL6]

  property p_or_file;
    @(posedge clk_sys) disable iff (!rst_b)
    take && instr_op == or_acc_file && !dest_bit |=> !file_we_q
      && acc_q == ($past(acc_q) | $past(file_rdata));
  endproperty
  a_or_file: assert property (p_or_file) else $error("or-register wrong"); // [RL7]

  property p_move_self;
    @(posedge clk_sys) disable iff (!rst_b)
    take && instr_op == move_file && dest_bit |=> file_we_q && $stable(acc_q)
      && file_waddr_q == $past(file_addr) && zero_q == ($past(file_rdata) == 8'h00);
  endproperty
  a_move_self: assert property (p_move_self) else $error("move to self wrong"); // [RL9]

  property p_move_acc;
    @(posedge clk_sys) disable iff (!rst_b)
    take && instr_op == move_file && !dest_bit |=> acc_q == $past(file_rdata) && !file_we_q;
  endproperty
  a_move_acc: assert property (p_move_acc) else $error("move to accumulator wrong"); // [RL8]

  property p_single;
    @(posedge clk_sys) disable iff (!rst_b)
    take && !long_instr |=> done_q && !busy_q && pc_q == 13'($past(pc_q) + 13'h0001);
  endproperty
  a_single: assert property (p_single) else $error("plain instruction not one cycle"); // [RL10]
endmodule

//--- bench/tb_top.sv
module tb_top
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    exec_op_t   op;
    logic       d;
    logic [7:0] lit;
    logic [7:0] fd;
    logic [7:0] acc;
    logic       z;
    logic       we;
    logic [7:0] wd;
  } row_t;

  logic        clk_sys, rst_b, instr_valid, dest_bit;
  exec_op_t    instr_op;
  logic [6:0]  file_addr, file_waddr_q;
  logic [10:0] literal;
  logic [7:0]  file_rdata, acc_q, file_wdata_q;
  logic [4:0]  pc_high_latch;
  logic        busy_q, done_q, nop_cycle_q, zero_q, file_we_q;
  logic [12:0] pc_q;
  int          fail_count, samples_checked;

  // ------------------------------------------------------------
  // Rows carry over the accumulator and flag from the row before
  // ------------------------------------------------------------
  row_t rows [13] = '{
    '{or_literal_acc,      1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
    '{or_literal_acc,      1'b0, 8'h5a, 8'h00, 8'h5a, 1'b0, 1'b0, 8'h00},
    '{increment_file,      1'b0, 8'h00, 8'h7f, 8'h80, 1'b0, 1'b0, 8'h00},
    '{increment_file,      1'b1, 8'h00, 8'hff, 8'h80, 1'b1, 1'b1, 8'h00},
    '{or_acc_file,         1'b0, 8'h00, 8'h01, 8'h81, 1'b0, 1'b0, 8'h00},
    '{or_acc_file,         1'b1, 8'h00, 8'h10, 8'h81, 1'b0, 1'b1, 8'h91},
    '{move_file,           1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
    '{move_file,           1'b1, 8'h00, 8'h33, 8'h00, 1'b0, 1'b1, 8'h33},
    '{increment_skip_zero, 1'b0, 8'h00, 8'h41, 8'h42, 1'b0, 1'b0, 8'h00},
    '{increment_skip_zero, 1'b1, 8'h00, 8'h05, 8'h42, 1'b0, 1'b1, 8'h06},
    '{move_file,           1'b1, 8'h00, 8'h00, 8'h42, 1'b1, 1'b1, 8'h00},
    '{increment_skip_zero, 1'b0, 8'h00, 8'h7e, 8'h7f, 1'b1, 1'b0, 8'h00},
    '{no_operation,        1'b0, 8'h00, 8'h00, 8'h7f, 1'b1, 1'b0, 8'h00}};

  increment_or_move_branch_exec dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .instr_valid(instr_valid), .instr_op(instr_op),
    .file_addr(file_addr), .dest_bit(dest_bit), .literal(literal),
    .file_rdata(file_rdata), .pc_high_latch(pc_high_latch), .busy_q(busy_q),
    .done_q(done_q), .nop_cycle_q(nop_cycle_q), .pc_q(pc_q), .acc_q(acc_q),
    .zero_q(zero_q), .file_we_q(file_we_q), .file_waddr_q(file_waddr_q),
    .file_wdata_q(file_wdata_q));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Wide enough for the packed groups of outputs compared in one call
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string name);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic drive(input exec_op_t op, input logic d, input logic [10:0] lit,
                       input logic [7:0] fd);
    instr_valid = 1'b1;
    instr_op    = op;
    dest_bit    = d;
    literal     = lit;
    file_rdata  = fd;
  endtask

  task automatic branch(input logic [4:0] latch, input logic [10:0] lit,
                        input logic [12:0] exp_pc);
    @(posedge clk_sys); #1;
    pc_high_latch = latch;
    drive(absolute_branch, 1'b0, lit, 8'h00);
    @(posedge clk_sys); #1;
    instr_valid = 1'b0;
    check(pc_q, exp_pc, "branch pc");
    check(busy_q, 1'b1, "branch busy");
    check(done_q, 1'b0, "branch early done");
    check(zero_q, 1'b1, "branch zero");
    @(posedge clk_sys); #1;
    check(done_q, 1'b1, "branch done");
    check(busy_q, 1'b0, "branch busy end");
  endtask

  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Whole sequence needs well under a hundred cycles
  initial begin
    #50000;
    fail_count++;
    end_sim();
  end

  initial begin
    rst_b = 1'b0; instr_valid = 1'b0; instr_op = no_operation; file_addr = 7'h00;
    dest_bit = 1'b0; literal = 11'h000; file_rdata = 8'h00; pc_high_latch = 5'h00;
    repeat (6) @(posedge clk_sys);
    #1;
    check({acc_q, zero_q}, 9'h000, "reset acc zero");
    check(pc_q, 13'h0000, "reset pc");
    rst_b = 1'b1;
    @(posedge clk_sys); #1;
    // Back-to-back takes: each row is issued on the cycle after the previous one
    for (int i = 0; i < 13; i++) begin
      drive(rows[i].op, rows[i].d, {3'h0, rows[i].lit}, rows[i].fd);
      file_addr = i[6:0];
      @(posedge clk_sys); #1;
      check(acc_q, rows[i].acc, "acc");
      check(zero_q, rows[i].z, "zero");
      check(file_we_q, rows[i].we, "file write");
      if (rows[i].we) check({file_waddr_q, file_wdata_q}, {i[6:0], rows[i].wd}, "wr");
      check(pc_q, i[12:0] + 13'h1, "pc");
      check({done_q, busy_q, nop_cycle_q}, 3'b100, "one cycle");
    end
    instr_valid = 1'b0;
    @(posedge clk_sys); #1;
    file_addr = 7'h7f;
    drive(increment_skip_zero, 1'b1, 11'h000, 8'hff);
    @(posedge clk_sys); #1;
    check({file_we_q, file_waddr_q, file_wdata_q}, {1'b1, 7'h7f, 8'h00}, "skip wr");
    check({nop_cycle_q, busy_q, done_q}, 3'b110, "skip slot");
    check(pc_q, 13'h000f, "skip pc");
    check(zero_q, 1'b1, "skip zero");
    // Kept valid across the stall cycle; must be ignored
    instr_op = or_literal_acc;
    literal  = 11'h0ff;
    @(posedge clk_sys); #1;
    instr_valid = 1'b0;
    check({done_q, busy_q, nop_cycle_q}, 3'b100, "skip done");
    check(acc_q, 8'h7f, "refused acc");
    branch(5'b11000, 11'h5a5, 13'h1da5);
    branch(5'b01111, 11'h7ff, 13'h0fff);
    @(posedge clk_sys); #1;
    rst_b = 1'b0;
    #1;
    check({pc_q, acc_q}, 21'h000000, "mid reset");
    check({zero_q, done_q, busy_q, file_we_q}, 4'h0, "mid reset flags");
    @(posedge clk_sys); #1;
    // First request rides on the first edge after release
    rst_b = 1'b1;
    drive(or_literal_acc, 1'b0, 11'h0c3, 8'h00);
    @(posedge clk_sys); #1;
    instr_valid = 1'b0;
    check({pc_q, acc_q, zero_q}, 22'h000386, "post reset or");
    check({done_q, busy_q, file_we_q}, 3'b100, "post reset done");
    end_sim();
  end
endmodule
